// ===== bpsc_cfg.svh
`ifndef BPSC_CFG_SVH
`define BPSC_CFG_SVH
// ==========================================================
// timing constants (clock 200 MHz)
`define BPSC_CLK_HZ            200000000
`define BPSC_SAMPLE_MS         400
`define BPSC_SETTLE_MS         60
`define BPSC_IRQ_US            1800
`define BPSC_SAMPLE_CYC        (`BPSC_CLK_HZ / 1000 * `BPSC_SAMPLE_MS)
`define BPSC_SETTLE_CYC        (`BPSC_CLK_HZ / 1000 * `BPSC_SETTLE_MS)
`define BPSC_IRQ_CYC           (`BPSC_CLK_HZ / 1000000 * `BPSC_IRQ_US)
// capacitor-set delays: 50 s per uF, 0.1 ms per nF, 20 us comparator
`define BPSC_OVUV_S_PER_UF     50
`define BPSC_SC_US_PER_NF      100
`define BPSC_SC_CMP_US         20
// cell counts
`define BPSC_CELLS_MAX         13
`define BPSC_CELLS_ALT         10
`define BPSC_CELL_W            4
`define BPSC_MON_W             12
`endif

// ===== bpsc_pkg.sv
package bpsc_pkg;
    // gate pin drive level
    typedef enum logic [1:0]
    {
        BPSC_GATE_LOW  = 2'b00,
        BPSC_GATE_HIGH = 2'b01,
        BPSC_GATE_HIZ  = 2'b10
    } bpsc_gate_t;

    // readout sequencer states
    typedef enum logic [1:0]
    {
        BPSC_RO_IDLE = 2'b00,
        BPSC_RO_ARM  = 2'b01,
        BPSC_RO_RUN  = 2'b10
    } bpsc_ro_t;
endpackage : bpsc_pkg

// ===== bpsc_delay.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// qualification counter: out rises once cond held set_max
// cycles, and falls once cond absent clr_max cycles
module bpsc_delay
#(
    parameter int W = 32
)
(
    input  wire logic         clock,    // system clock
    input  wire logic         resetn,   // async reset, low
    input  wire logic         cond,     // raw condition
    input  wire logic [W-1:0] set_max,  // cycles to assert
    input  wire logic [W-1:0] clr_max,  // cycles to release
    output var  logic         out_q     // qualified level
);
    logic [W-1:0] cnt_q;

    // counter restarts whenever the input agrees with the output
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end
        else if (cond == out_q)
            cnt_q <= '0;
        else if (cnt_q >= ((cond ? set_max : clr_max) - W'(1)))
        begin
            cnt_q <= '0;
            out_q <= cond;
        end
        else
            cnt_q <= cnt_q + W'(1);
    end
endmodule : bpsc_delay
`default_nettype wire

// ===== bpsc_cellmem.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// per-cell sample store, registered read port
module bpsc_cellmem
#(
    parameter int N = 13,
    parameter int AW = 4,
    parameter int DW = 12
)
(
    input  wire logic          clock,   // system clock
    input  wire logic          we,      // write strobe
    input  wire logic [AW-1:0] waddr,   // write index
    input  wire logic [DW-1:0] wdata,   // write data
    input  wire logic [AW-1:0] raddr,   // read index
    output var  logic [DW-1:0] rdata_q  // registered read
);
    logic [DW-1:0] mem [N];

    // storage has no reset; one entry is rewritten per cycle while we is high
    always_ff @(posedge clock)
    begin
        if (we && (waddr < AW'(N)))
            mem[waddr] <= wdata;
        rdata_q <= (raddr < AW'(N)) ? mem[raddr] : '0;
    end
endmodule : bpsc_cellmem
`default_nettype wire

// ===== bpsc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpsc_cfg.svh"
module bpsc_ctrl
    import bpsc_pkg::*;
#(
    parameter int N       = `BPSC_CELLS_MAX,
    parameter int DW      = `BPSC_MON_W,
    parameter int SAMPLE  = `BPSC_SAMPLE_CYC,
    parameter int SETTLE  = `BPSC_SETTLE_CYC,
    parameter int IRQ     = `BPSC_IRQ_CYC,
    parameter int TEMP_DLY = `BPSC_SAMPLE_CYC,
    parameter int ISD_DLY = 200000,
    parameter int ISC_DLY = 200000,
    parameter int CAP_UF_X10 = 1,
    parameter int CAP_NF  = 1
)
(
    input  wire logic          clock,                 // 200 MHz clock
    input  wire logic          resetn,                // async reset, low
    input  wire logic          power_down,            // power-down state
    input  wire logic          cell_select_10,        // high: 10 cells
    input  wire logic          temp_hot_discharge,    // temp_sense_in at/below thr
    input  wire logic          temp_hot_charge,       // hot charge thr
    input  wire logic          temp_cold_charge,      // cold charge thr
    input  wire logic [N-1:0]  cell_over,             // per-cell ov cmp
    input  wire logic [N-1:0]  cell_ov_release,       // at/below release
    input  wire logic [N-1:0]  cell_under,            // per-cell uv cmp
    input  wire logic          short_cmp,             // short comparator
    input  wire logic          current_discharge,     // above disch thr
    input  wire logic          current_charge,        // charge-state cmp
    input  wire logic          discharge_force_off_n, // ext off, low
    input  wire logic [DW-1:0] cell_adc,              // selected cell value
    input  wire logic          readout_request_in,    // pin level in
    output logic               readout_request_oe,    // pin pull low
    output logic               readout_request_o,     // pin drive value
    output logic [DW-1:0]      cell_monitor_out,      // cell value x0.5
    output logic [3:0]         cell_sel,              // cell under measure
    output logic               discharge_gate_out,    // discharge gate high
    output logic               charge_gate_hiz,       // charge gate hi-z
    output logic               charge_gate_out,       // charge gate high
    output logic               ov_state,              // overvoltage state
    output logic               uv_state,              // undervoltage state
    output logic               short_state,           // short detected
    output logic               hot_discharge_state    // hot discharge state
);
    localparam int CW  = 32;
    localparam int OVUV = int'(longint'(SAMPLE) * 100 * CAP_UF_X10
                          * `BPSC_OVUV_S_PER_UF / `BPSC_SAMPLE_MS);
    localparam int SCD = `BPSC_CLK_HZ / 1000000
                         * (`BPSC_SC_US_PER_NF * CAP_NF + `BPSC_SC_CMP_US);
    localparam int SLOT = SAMPLE / N;

    // ======================================================
    // monitor timebase
    logic [CW-1:0] tick_cnt_q;
    logic          tick;
    logic [3:0]    slot_q;
    logic [CW-1:0] slot_cnt_q;

    // free 400 ms sample cycle split in equal cell slots
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            tick_cnt_q <= '0;
        else if (tick)
            tick_cnt_q <= '0;
        else
            tick_cnt_q <= tick_cnt_q + CW'(1);
    end
    assign tick = (tick_cnt_q == CW'(SAMPLE - 1));

    // slot stepping from lowest cell upward
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            slot_q     <= '0;
            slot_cnt_q <= '0;
        end
        else if (tick)
        begin
            slot_q     <= '0;
            slot_cnt_q <= '0;
        end
        else if (slot_cnt_q == CW'(SLOT - 1))
        begin
            slot_cnt_q <= '0;
            if (slot_q < 4'(N))
                slot_q <= slot_q + 4'h1;
        end
        else
            slot_cnt_q <= slot_cnt_q + CW'(1);
    end
    assign cell_sel = slot_q;

    // ======================================================
    // cell-count decode
    function automatic logic cell_used(input logic [3:0] idx,
                                       input logic sel10);
        cell_used = (idx < 4'(N)) &&
                    (!sel10 || idx >= 4'(N - `BPSC_CELLS_ALT));
    endfunction : cell_used

    logic [N-1:0] used_mask;
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_mask
            assign used_mask[g] = cell_used(4'(g), cell_select_10);
        end
    endgenerate

    // ======================================================
    // temperature sampled at the 400 ms tick only
    logic hot_d_s_q, hot_c_s_q, cold_c_s_q, ov_s_q, uv_s_q;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            hot_d_s_q  <= 1'b0;
            hot_c_s_q  <= 1'b0;
            cold_c_s_q <= 1'b0;
            ov_s_q     <= 1'b0;
            uv_s_q     <= 1'b0;
        end
        else if (tick)
        begin
            hot_d_s_q  <= temp_hot_discharge;
            hot_c_s_q  <= temp_hot_charge;
            cold_c_s_q <= temp_cold_charge;
            ov_s_q     <= |(cell_over & used_mask);
            uv_s_q     <= |(cell_under & used_mask);
        end
    end

    // ov release when all used cells at or below release
    logic ov_rel, ov_q, uv_q, hotd_q, hotc_q, coldc_q;
    assign ov_rel = &(cell_ov_release | ~used_mask);

    // ======================================================
    // detection delays as restarting counters
    logic isd_q, isc_q;
    bpsc_delay #(.W(CW)) u_hotd (.clock(clock), .resetn(resetn),
        .cond(hot_d_s_q), .set_max(CW'(TEMP_DLY)),
        .clr_max(CW'(TEMP_DLY)), .out_q(hotd_q));
    bpsc_delay #(.W(CW)) u_hotc (.clock(clock), .resetn(resetn),
        .cond(hot_c_s_q), .set_max(CW'(TEMP_DLY)),
        .clr_max(CW'(TEMP_DLY)), .out_q(hotc_q));
    bpsc_delay #(.W(CW)) u_coldc (.clock(clock), .resetn(resetn),
        .cond(cold_c_s_q), .set_max(CW'(TEMP_DLY)),
        .clr_max(CW'(TEMP_DLY)), .out_q(coldc_q));
    bpsc_delay #(.W(CW)) u_uv (.clock(clock), .resetn(resetn),
        .cond(uv_s_q), .set_max(CW'(OVUV)),
        .clr_max(CW'(1)), .out_q(uv_q));
    bpsc_delay #(.W(CW)) u_sc (.clock(clock), .resetn(resetn),
        .cond(short_cmp), .set_max(CW'(SCD)),
        .clr_max(CW'(1)), .out_q(short_state));
    bpsc_delay #(.W(CW)) u_isd (.clock(clock), .resetn(resetn),
        .cond(current_discharge), .set_max(CW'(ISD_DLY)),
        .clr_max(CW'(ISD_DLY)), .out_q(isd_q));
    bpsc_delay #(.W(CW)) u_isc (.clock(clock), .resetn(resetn),
        .cond(current_charge), .set_max(CW'(ISC_DLY)),
        .clr_max(CW'(ISC_DLY)), .out_q(isc_q));

    // ov entry delayed from the sample, exit on release
    logic [CW-1:0] ov_cnt_q;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ov_q     <= 1'b0;
            ov_cnt_q <= '0;
        end
        else if (ov_q)
        begin
            if (ov_rel)
                ov_q <= 1'b0;
        end
        else if (!ov_s_q)
            ov_cnt_q <= '0;
        else if (ov_cnt_q >= CW'(OVUV - 1))
        begin
            ov_q     <= 1'b1;
            ov_cnt_q <= '0;
        end
        else
            ov_cnt_q <= ov_cnt_q + CW'(1);
    end
    assign ov_state            = ov_q;
    assign uv_state            = uv_q;
    assign hot_discharge_state = hotd_q;

    // ======================================================
    // gate combination; held values cover "no change" entries
    logic d_on_q, c_on_q;
    logic d_inhibit, c_inhibit;
    assign d_inhibit = hotd_q | uv_q | short_state | power_down;
    assign c_inhibit = ov_q | hotc_q | coldc_q | short_state
                     | power_down;

    // protection state gate memory
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            d_on_q <= 1'b0;
            c_on_q <= 1'b0;
        end
        else
        begin
            if (d_inhibit)
                d_on_q <= 1'b0;
            else if (!c_inhibit || !d_on_q)
                d_on_q <= 1'b1;
            if (c_inhibit)
                c_on_q <= 1'b0;
            else
                c_on_q <= 1'b1;
        end
    end

    // output registers: overrides per current direction
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            discharge_gate_out <= 1'b0;
            charge_gate_out    <= 1'b0;
            charge_gate_hiz    <= 1'b1;
        end
        else
        begin
            if (isc_q && !power_down)
                discharge_gate_out <= 1'b1;
            else if (!discharge_force_off_n)
                discharge_gate_out <= 1'b0;
            else
                discharge_gate_out <= d_on_q;
            charge_gate_out <= (isd_q && !power_down) | c_on_q;
            charge_gate_hiz <= !((isd_q && !power_down) | c_on_q);
        end
    end

    // ======================================================
    // readout request pin sequencer
    bpsc_ro_t      ro_q;
    logic [CW-1:0] settle_q;
    logic [CW-1:0] irq_q;
    logic [3:0]    last_slot_q;
    logic          seen_low_q;

    // settling after reset or leaving power-down
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            settle_q <= CW'(SETTLE);
        else if (power_down)
            settle_q <= CW'(SETTLE);
        else if (settle_q != '0)
            settle_q <= settle_q - CW'(1);
    end

    // idle -> low seen -> release arms -> run at next cycle start
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ro_q       <= BPSC_RO_IDLE;
            seen_low_q <= 1'b0;
        end
        else if (power_down)
        begin
            ro_q       <= BPSC_RO_IDLE;
            seen_low_q <= 1'b0;
        end
        else
        begin
            case (ro_q)
                BPSC_RO_IDLE:
                begin
                    if (settle_q != '0)
                        seen_low_q <= 1'b0;
                    else if (!readout_request_in)
                        seen_low_q <= 1'b1;
                    else if (seen_low_q)
                    begin
                        seen_low_q <= 1'b0;
                        ro_q       <= BPSC_RO_ARM;
                    end
                end
                BPSC_RO_ARM:
                    if (tick)
                        ro_q <= BPSC_RO_RUN;
                BPSC_RO_RUN:
                    if (tick)
                        ro_q <= BPSC_RO_IDLE;
                default:
                    ro_q <= BPSC_RO_IDLE;
            endcase
        end
    end

    // interrupt pulse on each cell change
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_q       <= '0;
            last_slot_q <= '0;
        end
        else
        begin
            last_slot_q <= slot_q;
            if (ro_q == BPSC_RO_RUN && slot_q != last_slot_q
                && slot_q < 4'(N))
                irq_q <= CW'(IRQ);
            else if (ro_q != BPSC_RO_RUN)
                irq_q <= '0;
            else if (irq_q != '0)
                irq_q <= irq_q - CW'(1);
        end
    end
    assign readout_request_o  = 1'b0;
    assign readout_request_oe = (ro_q == BPSC_RO_RUN) && (irq_q != '0);

    // ======================================================
    // monitor output: stored sample halved
    logic [DW-1:0] mem_rd;
    logic          sel_ok_q;
    bpsc_cellmem #(.N(N), .AW(4), .DW(DW)) u_mem (
        .clock   (clock),
        .we      (slot_q < 4'(N)),
        .waddr   (slot_q),
        .wdata   (cell_adc),
        .raddr   (slot_q),
        .rdata_q (mem_rd)
    );

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sel_ok_q         <= 1'b0;
            cell_monitor_out <= '0;
        end
        else
        begin
            sel_ok_q <= (ro_q == BPSC_RO_RUN)
                        && cell_used(slot_q, cell_select_10);
            if (sel_ok_q && ro_q == BPSC_RO_RUN)
                cell_monitor_out <= mem_rd >> 1;
            else
                cell_monitor_out <= '0;
        end
    end
endmodule : bpsc_ctrl
`default_nettype wire

// ===== bpsc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checks on the protection controller
module bpsc_ctrl_assertions
#(
    parameter int DW       = 12,
    parameter int SAMPLE   = 260,
    parameter int IRQ      = 5,
    parameter int TEMP_DLY = 10
)
(
    input wire logic          clock,                 // clock
    input wire logic          resetn,                // reset, low
    input wire logic          power_down,            // in
    input wire logic          cell_select_10,        // in
    input wire logic          temp_hot_discharge,    // in
    input wire logic          temp_hot_charge,       // in
    input wire logic          temp_cold_charge,      // in
    input wire logic          current_discharge,     // in
    input wire logic          current_charge,        // in
    input wire logic          discharge_force_off_n, // in
    input wire logic          readout_request_oe,    // out
    input wire logic [DW-1:0] cell_monitor_out,      // out
    input wire logic [3:0]    cell_sel,              // out
    input wire logic          discharge_gate_out,    // out
    input wire logic          charge_gate_hiz,       // out
    input wire logic          charge_gate_out,       // out
    input wire logic          hot_discharge_state    // out
);
    // two tick samples plus margin: entry may wait a whole cycle
    localparam int LIM = 2 * SAMPLE + TEMP_DLY + 8;
    logic [15:0] hot_q;
    logic [15:0] chg_q;
    logic [15:0] oe_len_q;

    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // saturating run length, so a long soak never wraps
    function automatic logic [15:0] step(logic [15:0] q, logic c);
        return !c ? 16'h0000 : ((q == 16'hffff) ? q : q + 16'h0001);
    endfunction : step

    // how long each steady condition has held
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            hot_q <= '0;
            chg_q <= '0;
            oe_len_q <= '0;
        end
        else
        begin
            hot_q <= step(hot_q, temp_hot_discharge && !current_charge
                                 && !power_down);
            chg_q <= step(chg_q, (temp_cold_charge || temp_hot_charge)
                                 && !current_discharge && !power_down);
            oe_len_q <= step(oe_len_q, readout_request_oe);
        end
    end

    discharge_force_off_n_low_a : assert property (
        (!discharge_force_off_n && !current_charge) [*8]
        |-> !discharge_gate_out)
        else $error("discharge gate on while forced off");
    isc_win_a : assert property (
        (current_charge && !power_down) [*8] |-> discharge_gate_out)
        else $error("charge current did not force discharge gate");
    isd_chg_a : assert property (
        (current_discharge && !power_down) [*8]
        |-> charge_gate_out && !charge_gate_hiz)
        else $error("discharge current did not force charge gate");
    irq_width_a : assert property (
        $fell(readout_request_oe) |-> oe_len_q == 16'(IRQ))
        else $error("interrupt pulse width wrong");
    mon_none_a : assert property (
        (cell_sel == 4'hd) [*3] |-> cell_monitor_out == '0)
        else $error("monitor not zero with no cell");
    mon_unused_a : assert property (
        (cell_select_10 && cell_sel < 4'h3) [*3]
        |-> cell_monitor_out == '0)
        else $error("monitor not zero on unused cell");
    pd_quiet_a : assert property (
        power_down [*4] |-> !readout_request_oe)
        else $error("readout pin driven in power down");
    hot_dis_a : assert property (
        hot_q > 16'(LIM) |-> hot_discharge_state && !discharge_gate_out)
        else $error("hot discharge inhibit missing");
    chg_hiz_a : assert property (
        chg_q > 16'(LIM) |-> charge_gate_hiz)
        else $error("charge gate not released when too hot or cold");
endmodule : bpsc_ctrl_assertions

bind bpsc_ctrl bpsc_ctrl_assertions #(.DW(DW), .SAMPLE(SAMPLE), .IRQ(IRQ),
    .TEMP_DLY(TEMP_DLY)) chk (.*);
`default_nettype wire

// ===== bpsc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host on the readout pin: pulses to ask, then reads the
// monitor a little after each interrupt it sees
module bpsc_host
(
    input  wire logic        clock,    // clock
    input  wire logic        pin,      // resolved pin level
    input  wire logic        go,       // send one request pulse
    input  wire logic        hold,     // keep pin low
    input  wire logic [11:0] mon,      // monitor output
    output var  logic        pull_low, // host pulls pin low
    output var  logic        got,      // reading taken
    output var  logic [11:0] val,      // reading
    output var  int          irqs      // interrupts seen
);
    logic [3:0] pls_q = '0;
    logic [3:0] rd_q = '0;
    logic       pin_q = 1'b1;

    // a short low pulse, then release: release is what asks
    assign pull_low = hold || (pls_q != 4'h0);

    // own pulls are not interrupts; read mid-slot, once settled
    always @(posedge clock)
    begin
        pin_q <= pin;
        got <= 1'b0;
        if (go && pls_q == 4'h0)
            pls_q <= 4'h4;
        else if (pls_q != 4'h0)
            pls_q <= pls_q - 4'h1;
        if (pin_q && !pin && !pull_low)
        begin
            irqs <= irqs + 1;
            rd_q <= 4'h8;
        end
        else if (rd_q != 4'h0)
            rd_q <= rd_q - 4'h1;
        if (rd_q == 4'h1)
        begin
            got <= 1'b1;
            val <= mon;
        end
    end
    initial irqs = 0;
endmodule : bpsc_host
`default_nettype wire

// ===== bpsc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench: host model on the pin, direct stimulus elsewhere
module bpsc_ctrl_tb;
    localparam int SAMPLE = 263;
    localparam int SETTLE = 50;
    logic             clock = 1'b0;
    logic             resetn = 1'b0;
    logic             power_down = 1'b0;
    logic             cell_select_10 = 1'b0;
    logic             temp_hot_discharge = 1'b0;
    logic             temp_hot_charge = 1'b0;
    logic             temp_cold_charge = 1'b0;
    logic [12:0]      cell_over = '0;
    logic [12:0]      cell_ov_release = '1;
    logic [12:0]      cell_under = '0;
    logic             short_cmp = 1'b0;
    logic             current_discharge = 1'b0;
    logic             current_charge = 1'b0;
    logic             discharge_force_off_n = 1'b1;
    logic             go = 1'b0;
    logic             hold = 1'b0;
    logic [11:0]      base = '0;
    wire logic [11:0] cell_adc;
    wire logic        readout_request_in;
    logic             readout_request_oe, readout_request_o, pull_low, got;
    logic             discharge_gate_out, charge_gate_hiz, charge_gate_out;
    logic             ov_state, uv_state, short_state, hot_discharge_state;
    logic [11:0]      cell_monitor_out, val;
    logic [3:0]       cell_sel;
    logic [11:0]      exp_q[$];
    int               irqs, mismatches = 0, comparisons = 0;

    // pull-up on the pin; either side may pull it low
    assign readout_request_in = !(readout_request_oe || pull_low);
    // front end gives each cell a level of its own
    assign cell_adc = base ^ {cell_sel, cell_sel, cell_sel};

    initial
    begin
        forever #2.5 clock = ~clock;
    end

    bpsc_ctrl #(.SAMPLE(SAMPLE), .SETTLE(SETTLE), .IRQ(5), .TEMP_DLY(10),
                .ISD_DLY(4), .ISC_DLY(4), .CAP_NF(0)) uut (.*);
    bpsc_host host (.clock, .pin(readout_request_in), .go, .hold,
                    .mon(cell_monitor_out), .pull_low, .got, .val, .irqs);

    task automatic check(input string n, input logic [11:0] e,
                         input logic [11:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check

    task automatic print_verdict();
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // each reading the host takes meets the oldest note
    always @(posedge clock)
    begin
        if (got && exp_q.size() > 0)
            check("monitor", exp_q.pop_front(), val);
        else if (got)
            check("extra reading", 12'h000, 12'hfff);
    end

    // a request that must be ignored: no interrupt may follow
    task automatic quiet(input logic use_hold);
        int n0;
        logic seen;
        n0 = irqs;
        seen = 1'b0;
        go <= !use_hold;
        hold <= use_hold;
        @(posedge clock);
        go <= 1'b0;
        // the host hides pulls under its own hold, so watch the pin too
        repeat (3 * SAMPLE)
        begin
            @(posedge clock);
            seen |= readout_request_oe;
        end
        check("interrupts", 12'h000, 12'(irqs - n0));
        check("pin driven", 12'h000, 12'(seen));
    endtask : quiet

    // full readout; every cell slot, the first included, raises an interrupt
    task automatic readout(input logic sel10, input logic use_hold);
        int n0;
        int k;
        n0 = irqs;
        k = 0;
        cell_select_10 <= sel10;
        for (int i = 0; i < 13; i++)
            exp_q.push_back((sel10 && i < 3) ? 12'h000
                            : (base ^ {3{i[3:0]}}) >> 1);
        go <= !use_hold;
        hold <= 1'b0;
        @(posedge clock);
        go <= 1'b0;
        while (exp_q.size() > 0 && k < 4 * SAMPLE)
        begin
            @(posedge clock);
            k++;
        end
        if (k >= 4 * SAMPLE)
        begin
            mismatches++;
            print_verdict();
        end
        repeat (40) @(posedge clock);
        check("interrupts", 12'h00d, 12'(irqs - n0));
        check("pin level", 12'h000, 12'(readout_request_o));
        check("pin driven", 12'h000, 12'(readout_request_oe));
        check("idle monitor", 12'h000, cell_monitor_out);
    endtask : readout

    // gate levels after a long steady spell
    task automatic gates(input logic [2:0] e);
        repeat (3 * SAMPLE) @(posedge clock);
        check("discharge gate", 12'(e[2]), 12'(discharge_gate_out));
        check("charge gate", 12'(e[1]), 12'(charge_gate_out));
        check("charge hiz", 12'(e[0]), 12'(charge_gate_hiz));
    endtask : gates

    initial
    begin
        void'($urandom(32'h2721));
        base = 12'($urandom);
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        quiet(1'b0);
        readout(1'b0, 1'b0);
        readout(1'b1, 1'b0);
        quiet(1'b1);
        readout(1'b0, 1'b1);
        power_down <= 1'b1;
        quiet(1'b0);
        power_down <= 1'b0;
        gates(3'b110);
        temp_cold_charge <= 1'b1;
        gates(3'b101);
        temp_hot_discharge <= 1'b1;
        gates(3'b001);
        temp_cold_charge <= 1'b0;
        temp_hot_charge <= 1'b1;
        gates(3'b001);
        temp_hot_charge <= 1'b0;
        temp_hot_discharge <= 1'b0;
        discharge_force_off_n <= 1'b0;
        current_charge <= 1'b1;
        repeat (20) @(posedge clock);
        check("forced on", 12'h001, 12'(discharge_gate_out));
        current_charge <= 1'b0;
        repeat (20) @(posedge clock);
        check("forced off", 12'h000, 12'(discharge_gate_out));
        // ov/uv: sample lag plus 5 s per 0.1 uF; short: 20 us comparator
        cell_over <= 13'h0001;
        cell_ov_release <= 13'h1ffe;
        cell_under <= 13'h1000;
        short_cmp <= 1'b1;
        repeat (3200) @(posedge clock);
        check("ov early", 12'h000, 12'(ov_state));
        check("short early", 12'h000, 12'(short_state));
        repeat (900) @(posedge clock);
        check("ov", 12'h001, 12'(ov_state));
        check("uv", 12'h001, 12'(uv_state));
        check("short", 12'h001, 12'(short_state));
        cell_over <= '0;
        cell_under <= '0;
        short_cmp <= 1'b0;
        repeat (3) @(posedge clock);
        check("ov held", 12'h001, 12'(ov_state));
        cell_ov_release <= '1;
        repeat (2 * SAMPLE) @(posedge clock);
        check("ov released", 12'h000, 12'(ov_state));
        check("uv released", 12'h000, 12'(uv_state));
        check("short released", 12'h000, 12'(short_state));
        // mixed current, short and off levels; the checker judges
        repeat (60)
        begin
            {short_cmp, current_charge, current_discharge,
             discharge_force_off_n} <= 4'($urandom);
            repeat ($urandom_range(20, 1)) @(posedge clock);
        end
        print_verdict();
    end
endmodule : bpsc_ctrl_tb
`default_nettype wire
